// ---- rtl/mmd_pkg.sv ----
// constants and address map for the memory map decoder
// What this block does
// - decode a flat 16-bit, 64-Kbyte processor address space
// - separate regions for 8192 FLASH, 512 RAM and 48 vector bytes
// - $0000 to $003F selects the peripheral register block
// - $FE20 to $FF7D selects read-only monitor storage, writes dropped
// - system registers at $FE00 to $FE0F with reserved holes
// - irq status three read-only, converter flag bit 2, keyboard bit 1
// - flash control holds high voltage, mass, erase, program in bits 3..0
// - breakpoint address high and low bytes, read/write, reset zero
// - breakpoint control holds enable bit 7 and active flag bit 6
// - low voltage status: detect, irq enable, irq flag, write-only ack
// - block protect byte at $FF7E is FLASH, untouched by reset
// - vector addresses in fixed priority from reset down to converter
// - RAM decoded at $0080 to $027F
// - user FLASH $DE00 to $FDFF, vector FLASH $FFD0 to $FFFF
package mmd_pkg;
    localparam logic [15:0] IO_LO      = 16'h0000;
    localparam logic [15:0] IO_HI      = 16'h003f;
    localparam logic [15:0] RAM_LO     = 16'h0080;
    localparam logic [15:0] RAM_HI     = 16'h027f;
    localparam logic [15:0] FLASH_LO   = 16'hde00;
    localparam logic [15:0] FLASH_HI   = 16'hfdff;
    localparam logic [15:0] SYS_LO     = 16'hfe00;
    localparam logic [15:0] SYS_HI     = 16'hfe0f;
    localparam logic [15:0] MON_LO     = 16'hfe20;
    localparam logic [15:0] MON_HI     = 16'hff7d;
    localparam logic [15:0] VEC_LO     = 16'hffd0;
    localparam logic [15:0] VEC_HI     = 16'hffff;

    localparam logic [15:0] BREAK_STATUS_ADDR   = 16'hfe00;
    localparam logic [15:0] RESET_CAUSE_ADDR    = 16'hfe01;
    localparam logic [15:0] BREAK_FLAG_CTL_ADDR = 16'hfe03;
    localparam logic [15:0] IRQ_ONE_ADDR        = 16'hfe04;
    localparam logic [15:0] IRQ_TWO_ADDR        = 16'hfe05;
    localparam logic [15:0] IRQ_THREE_ADDR      = 16'hfe06;
    localparam logic [15:0] FLASH_CTL_ADDR      = 16'hfe08;
    localparam logic [15:0] BKPT_HIGH_ADDR      = 16'hfe0c;
    localparam logic [15:0] BKPT_LOW_ADDR       = 16'hfe0d;
    localparam logic [15:0] BKPT_CTL_ADDR       = 16'hfe0e;
    localparam logic [15:0] LOW_VOLT_ADDR       = 16'hfe0f;
    localparam logic [15:0] BLOCK_PROTECT_ADDR  = 16'hff7e;
    localparam logic [15:0] WATCHDOG_ADDR       = 16'hffff;

    // field positions
    localparam int IRQ3_CONV_BIT   = 2;
    localparam int IRQ3_KBD_BIT    = 1;
    localparam int FC_HV_BIT       = 3;
    localparam int FC_MASS_BIT     = 2;
    localparam int FC_ERASE_BIT    = 1;
    localparam int FC_PROG_BIT     = 0;
    localparam int BC_ENABLE_BIT   = 7;
    localparam int BC_ACTIVE_BIT   = 6;
    localparam int LV_DETECT_BIT   = 7;
    localparam int LV_IE_BIT       = 6;
    localparam int LV_FLAG_BIT     = 5;
    localparam int LV_ACK_BIT      = 4;

    localparam logic [7:0] REG_RESET = 8'h00;

    // interrupt sources, index 0 highest priority
    localparam int NUM_VEC = 13;
    localparam logic [NUM_VEC-1:0][15:0] VEC_ADDR = {
        16'hffda,   // 12 converter complete
        16'hffdc,   // 11 keyboard
        16'hffea,   // 10 timer two overflow
        16'hffec,   // 9  timer two channel 1
        16'hffee,   // 8  timer two channel 0
        16'hfff0,   // 7  timer one overflow
        16'hfff2,   // 6  timer one channel 1
        16'hfff4,   // 5  timer one channel 0
        16'hfff6,   // 4  pll
        16'hfff8,   // 3  low voltage
        16'hfffa,   // 2  external irq
        16'hfffc,   // 1  software interrupt
        16'hfffe    // 0  reset
    };
endpackage

// ---- rtl/mmd_decoder.sv ----
// memory map decoder with system register group and vector selection
module mmd_decoder (
    input  wire logic        clk_sys,             // system bus clock
    input  wire logic        reset,               // async reset, active high
    input  wire logic [15:0] cpu_addr,            // processor address
    input  wire logic [7:0]  cpu_wdata,           // processor write data
    input  wire logic        cpu_rd,              // read strobe
    input  wire logic        cpu_wr,              // write strobe
    output logic      [7:0]  cpu_rdata_q,         // registered read data
    output logic             sel_io,              // peripheral block select
    output logic             sel_ram,             // RAM select
    output logic             sel_flash,           // user FLASH select
    output logic             sel_vector,          // vector FLASH select
    output logic             sel_monitor,         // monitor ROM select
    output logic             mem_wr,              // write to writable region
    input  wire logic [7:0]  io_rdata,            // peripheral read data
    input  wire logic [7:0]  ram_rdata,           // RAM read data
    input  wire logic [7:0]  flash_rdata,         // FLASH array read data
    input  wire logic [7:0]  rom_rdata,           // monitor ROM read data
    input  wire logic [7:0]  break_status_in,     // break status value
    input  wire logic [7:0]  reset_cause_in,      // reset cause value
    input  wire logic [7:0]  break_flag_ctl_in,   // break flag control value
    input  wire logic [7:0]  irq_status_one_in,   // irq status one value
    input  wire logic [7:0]  irq_status_two_in,   // irq status two value
    output logic             break_flag_ctl_wr,   // write pulse to break flag ctl
    input  wire logic        converter_done_flag, // converter irq pending
    input  wire logic        keyboard_irq_flag,   // keyboard irq pending
    input  wire logic        voltage_detect_out,  // low voltage detector level
    output logic             voltage_irq,         // low voltage irq request
    output logic             high_voltage_enable, // flash charge pump on
    output logic             mass_select,         // flash mass erase
    output logic             erase_select,        // flash erase
    output logic             program_select,      // flash program
    output logic             break_request,       // breakpoint hit
    output logic             watchdog_clear,      // watchdog service pulse
    input  wire logic [12:0] irq_pending,         // sources, bit 0 highest
    output logic [15:0]      vector_addr_q        // selected vector, even byte
);

    logic [7:0] irq_three;
    logic [7:0] flash_ctl_q;
    logic [7:0] bkpt_high_q;
    logic [7:0] bkpt_low_q;
    logic       bkpt_enable_q;
    logic       bkpt_active_q;
    logic       lv_ie_q;
    logic       lv_flag_q;
    logic       lv_detect_q;
    logic       in_sys;
    logic       in_reserved;
    logic [7:0] rdata_d;
    logic [15:0] vector_addr_d;
    logic       wr_flash_ctl;
    logic       wr_bkpt_ctl;
    logic       wr_low_volt;
    logic       bkpt_hit;
    logic       lv_rise;
    logic       wr_bkpt_high;
    logic       wr_bkpt_low;
    logic [7:0] flash_ctl_d;
    logic       erase_prog_both;
    logic       hv_allowed;
    logic       bkpt_active_d;
    logic       lv_flag_d;
    logic [12:0] higher_pending;
    logic [12:0] irq_win;

    // region decode
    always_comb begin
        sel_io = (cpu_addr <= mmd_pkg::IO_HI);
    end

    always_comb begin
        sel_ram = (cpu_addr >= mmd_pkg::RAM_LO) && (cpu_addr <= mmd_pkg::RAM_HI);
    end

    always_comb begin
        sel_flash = ((cpu_addr >= mmd_pkg::FLASH_LO) && (cpu_addr <= mmd_pkg::FLASH_HI))
                    || (cpu_addr == mmd_pkg::BLOCK_PROTECT_ADDR);
    end

    always_comb begin
        sel_vector = (cpu_addr >= mmd_pkg::VEC_LO) && (cpu_addr <= mmd_pkg::VEC_HI);
    end

    always_comb begin
        sel_monitor = (cpu_addr >= mmd_pkg::MON_LO) && (cpu_addr <= mmd_pkg::MON_HI);
    end

    always_comb begin
        in_sys = (cpu_addr >= mmd_pkg::SYS_LO) && (cpu_addr <= mmd_pkg::SYS_HI);
    end

    // reserved holes in the system group
    always_comb begin
        in_reserved = in_sys && ((cpu_addr == 16'hfe02) || (cpu_addr == 16'hfe07)
                      || ((cpu_addr >= 16'hfe09) && (cpu_addr <= 16'hfe0b)));
    end

    // monitor storage never sees a write; protect byte changes only by programming
    always_comb begin
        mem_wr = cpu_wr && (sel_io || sel_ram || sel_flash || sel_vector)
                 && (cpu_addr != mmd_pkg::BLOCK_PROTECT_ADDR);
    end

    always_comb begin
        wr_flash_ctl = cpu_wr && (cpu_addr == mmd_pkg::FLASH_CTL_ADDR);
    end

    always_comb begin
        wr_bkpt_ctl = cpu_wr && (cpu_addr == mmd_pkg::BKPT_CTL_ADDR);
    end

    always_comb begin
        wr_bkpt_high = cpu_wr && (cpu_addr == mmd_pkg::BKPT_HIGH_ADDR);
    end

    always_comb begin
        wr_bkpt_low = cpu_wr && (cpu_addr == mmd_pkg::BKPT_LOW_ADDR);
    end

    always_comb begin
        wr_low_volt = cpu_wr && (cpu_addr == mmd_pkg::LOW_VOLT_ADDR);
    end

    always_comb begin
        break_flag_ctl_wr = cpu_wr && (cpu_addr == mmd_pkg::BREAK_FLAG_CTL_ADDR);
    end

    always_comb begin
        watchdog_clear = cpu_wr && (cpu_addr == mmd_pkg::WATCHDOG_ADDR);
    end

    always_comb begin
        irq_three = 8'h00;
        irq_three[mmd_pkg::IRQ3_CONV_BIT] = converter_done_flag;
        irq_three[mmd_pkg::IRQ3_KBD_BIT]  = keyboard_irq_flag;
    end

    // flash control: erase and program interlocked, high voltage needs one of them
    always_comb begin
        erase_prog_both = cpu_wdata[mmd_pkg::FC_ERASE_BIT] && cpu_wdata[mmd_pkg::FC_PROG_BIT];
    end

    // high voltage judged on bits already held, not on this write
    always_comb begin
        hv_allowed = flash_ctl_q[mmd_pkg::FC_ERASE_BIT] || flash_ctl_q[mmd_pkg::FC_PROG_BIT];
    end

    always_comb begin
        flash_ctl_d = flash_ctl_q;
        if (wr_flash_ctl) begin
            flash_ctl_d[7:4] = 4'h0;
            flash_ctl_d[mmd_pkg::FC_MASS_BIT] = cpu_wdata[mmd_pkg::FC_MASS_BIT];
            if (!erase_prog_both) begin
                flash_ctl_d[mmd_pkg::FC_ERASE_BIT] = cpu_wdata[mmd_pkg::FC_ERASE_BIT];
                flash_ctl_d[mmd_pkg::FC_PROG_BIT]  = cpu_wdata[mmd_pkg::FC_PROG_BIT];
            end
            if (!cpu_wdata[mmd_pkg::FC_HV_BIT]) begin
                flash_ctl_d[mmd_pkg::FC_HV_BIT] = 1'b0;
            end else if (hv_allowed) begin
                flash_ctl_d[mmd_pkg::FC_HV_BIT] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            flash_ctl_q <= mmd_pkg::REG_RESET;
        end else begin
            flash_ctl_q <= flash_ctl_d;
        end
    end

    always_comb begin
        high_voltage_enable = flash_ctl_q[mmd_pkg::FC_HV_BIT];
    end

    always_comb begin
        mass_select = flash_ctl_q[mmd_pkg::FC_MASS_BIT];
    end

    always_comb begin
        erase_select = flash_ctl_q[mmd_pkg::FC_ERASE_BIT];
    end

    always_comb begin
        program_select = flash_ctl_q[mmd_pkg::FC_PROG_BIT];
    end

    // breakpoint address
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bkpt_high_q <= mmd_pkg::REG_RESET;
            bkpt_low_q  <= mmd_pkg::REG_RESET;
        end else begin
            if (wr_bkpt_high) begin
                bkpt_high_q <= cpu_wdata;
            end
            if (wr_bkpt_low) begin
                bkpt_low_q <= cpu_wdata;
            end
        end
    end

    always_comb begin
        bkpt_hit = bkpt_enable_q && (cpu_rd || cpu_wr) && (cpu_addr == {bkpt_high_q, bkpt_low_q});
    end

    always_comb begin
        break_request = bkpt_hit;
    end

    // a hit outranks a clearing write in the same cycle
    always_comb begin
        bkpt_active_d = bkpt_active_q;
        if (bkpt_hit) begin
            bkpt_active_d = 1'b1;
        end else if (wr_bkpt_ctl) begin
            bkpt_active_d = cpu_wdata[mmd_pkg::BC_ACTIVE_BIT];
        end
    end

    // breakpoint control; a hit in the clearing cycle keeps the flag set
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bkpt_enable_q <= 1'b0;
            bkpt_active_q <= 1'b0;
        end else begin
            if (wr_bkpt_ctl) begin
                bkpt_enable_q <= cpu_wdata[mmd_pkg::BC_ENABLE_BIT];
            end
            bkpt_active_q <= bkpt_active_d;
        end
    end

    // low voltage: flag on rising detect, cleared by writing the ack bit
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lv_detect_q <= 1'b0;
        end else begin
            lv_detect_q <= voltage_detect_out;
        end
    end

    always_comb begin
        lv_rise = voltage_detect_out && !lv_detect_q;
    end

    always_comb begin
        voltage_irq = lv_flag_q && lv_ie_q;
    end

    // a new rise outranks the acknowledge in the same cycle
    always_comb begin
        lv_flag_d = lv_flag_q;
        if (lv_rise) begin
            lv_flag_d = 1'b1;
        end else if (wr_low_volt && cpu_wdata[mmd_pkg::LV_ACK_BIT]) begin
            lv_flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lv_ie_q   <= 1'b0;
            lv_flag_q <= 1'b0;
        end else begin
            if (wr_low_volt) begin
                lv_ie_q <= cpu_wdata[mmd_pkg::LV_IE_BIT];
            end
            lv_flag_q <= lv_flag_d;
        end
    end

    // read mux
    always_comb begin
        rdata_d = 8'h00;
        if (sel_io) begin
            rdata_d = io_rdata;
        end else if (sel_ram) begin
            rdata_d = ram_rdata;
        end else if (sel_flash || sel_vector) begin
            rdata_d = flash_rdata;
        end else if (sel_monitor) begin
            rdata_d = rom_rdata;
        end else if (in_sys && !in_reserved) begin
            case (cpu_addr)
                mmd_pkg::BREAK_STATUS_ADDR:   rdata_d = break_status_in;
                mmd_pkg::RESET_CAUSE_ADDR:    rdata_d = reset_cause_in;
                mmd_pkg::BREAK_FLAG_CTL_ADDR: rdata_d = break_flag_ctl_in;
                mmd_pkg::IRQ_ONE_ADDR:        rdata_d = irq_status_one_in;
                mmd_pkg::IRQ_TWO_ADDR:        rdata_d = irq_status_two_in;
                mmd_pkg::IRQ_THREE_ADDR:      rdata_d = irq_three;
                mmd_pkg::FLASH_CTL_ADDR:      rdata_d = flash_ctl_q;
                mmd_pkg::BKPT_HIGH_ADDR:      rdata_d = bkpt_high_q;
                mmd_pkg::BKPT_LOW_ADDR:       rdata_d = bkpt_low_q;
                mmd_pkg::BKPT_CTL_ADDR:       rdata_d = {bkpt_enable_q, bkpt_active_q, 6'h00};
                mmd_pkg::LOW_VOLT_ADDR:       rdata_d = {voltage_detect_out, lv_ie_q, lv_flag_q, 5'h00};
                default:                      rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cpu_rdata_q <= 8'h00;
        end else if (cpu_rd) begin
            cpu_rdata_q <= rdata_d;
        end
    end

    // priority chain: a source wins only when nothing above it is pending
    generate
        for (genvar g = 0; g < mmd_pkg::NUM_VEC; g++) begin : g_prio
            if (g == 0) begin : g_top
                assign higher_pending[g] = 1'b0;
            end else begin : g_rest
                assign higher_pending[g] = higher_pending[g-1] || irq_pending[g-1];
            end
            assign irq_win[g] = irq_pending[g] && !higher_pending[g];
        end
    endgenerate

    // nothing pending shows the reset vector
    always_comb begin
        vector_addr_d = mmd_pkg::VEC_ADDR[0];
        for (int i = 0; i < mmd_pkg::NUM_VEC; i++) begin
            if (irq_win[i]) begin
                vector_addr_d = mmd_pkg::VEC_ADDR[i];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            vector_addr_q <= mmd_pkg::VEC_ADDR[0];
        end else begin
            vector_addr_q <= vector_addr_d;
        end
    end

endmodule

// ---- verif/mmd_decoder_properties.sv ----
// port-level assertions for the memory map decoder
module mmd_decoder_properties (
    input wire logic        clk_sys,             // clock
    input wire logic        reset,               // async reset
    input wire logic [15:0] cpu_addr,            // address
    input wire logic        cpu_rd,              // read strobe
    input wire logic        cpu_wr,              // write strobe
    input wire logic [7:0]  cpu_rdata_q,         // read data
    input wire logic        sel_io,              // io select
    input wire logic        sel_ram,             // ram select
    input wire logic        sel_flash,           // flash select
    input wire logic        sel_vector,          // vector select
    input wire logic        sel_monitor,         // monitor select
    input wire logic        mem_wr,              // memory write
    input wire logic        break_flag_ctl_wr,   // break flag ctl write pulse
    input wire logic        watchdog_clear,      // watchdog service pulse
    input wire logic        converter_done_flag, // converter flag
    input wire logic        keyboard_irq_flag,   // keyboard flag
    input wire logic        high_voltage_enable, // charge pump
    input wire logic        erase_select,        // erase
    input wire logic        program_select,      // program
    input wire logic [12:0] irq_pending,         // pending sources
    input wire logic [15:0] vector_addr_q        // chosen vector
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    function automatic logic [15:0] top_vec(input logic [12:0] p);
        for (int i = 0; i < 13; i++) begin
            if (p[i]) begin
                return mmd_pkg::VEC_ADDR[i];
            end
        end
        return 16'hfffe;
    endfunction

    property p_sel_io;
        sel_io == (cpu_addr <= 16'h003f);
    endproperty
    a_sel_io: assert property (p_sel_io) else $error("io select wrong");
    property p_sel_ram;
        sel_ram == (cpu_addr inside {[16'h0080:16'h027f]});
    endproperty
    a_sel_ram: assert property (p_sel_ram) else $error("ram select wrong");
    property p_sel_flash;
        sel_flash == (cpu_addr inside {[16'hde00:16'hfdff], 16'hff7e});
    endproperty
    a_sel_flash: assert property (p_sel_flash) else $error("flash select wrong");
    property p_sel_monitor;
        sel_monitor == (cpu_addr inside {[16'hfe20:16'hff7d]});
    endproperty
    a_sel_monitor: assert property (p_sel_monitor) else $error("monitor select wrong");
    property p_mem_wr;
        mem_wr == (cpu_wr && (cpu_addr inside {[16'h0000:16'h003f], [16'h0080:16'h027f],
                                               [16'hde00:16'hfdff], [16'hffd0:16'hffff]}));
    endproperty
    a_mem_wr: assert property (p_mem_wr) else $error("memory write wrong");
    property p_rsvd_zero;
        cpu_rd && (cpu_addr inside {16'hfe02, 16'hfe07, [16'hfe09:16'hfe0b]}) |=> cpu_rdata_q == 8'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero");
    property p_irq3;
        cpu_rd && cpu_addr == 16'hfe06
            |=> cpu_rdata_q == {5'h00, $past(converter_done_flag), $past(keyboard_irq_flag), 1'b0};
    endproperty
    a_irq3: assert property (p_irq3) else $error("irq status three wrong");
    property p_vector;
        1'b1 |=> vector_addr_q == top_vec($past(irq_pending));
    endproperty
    a_vector: assert property (p_vector) else $error("vector wrong");
    property p_hv_rise;
        $rose(high_voltage_enable) |-> $past(erase_select || program_select);
    endproperty
    a_hv_rise: assert property (p_hv_rise) else $error("high voltage set early");
    property p_flag_ctl_wr;
        break_flag_ctl_wr == (cpu_wr && cpu_addr == 16'hfe03);
    endproperty
    a_flag_ctl_wr: assert property (p_flag_ctl_wr) else $error("break flag ctl pulse wrong");
    property p_wdog_clear;
        watchdog_clear == (cpu_wr && cpu_addr == 16'hffff);
    endproperty
    a_wdog_clear: assert property (p_wdog_clear) else $error("watchdog clear wrong");
endmodule

bind mmd_decoder mmd_decoder_properties i_mmd_decoder_properties (.*);

// ---- verif/mmd_cpu_model.sv ----
// processor bus master model: one-cycle strobes, released bus shows inverse
module mmd_cpu_model (
    input  wire logic        clk_sys,     // clock
    input  wire logic [7:0]  cpu_rdata_q, // read data
    output logic      [15:0] cpu_addr,    // address
    output logic      [7:0]  cpu_wdata,   // write data
    output logic             cpu_rd,      // read strobe
    output logic             cpu_wr       // write strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cpu_addr = 16'h5a5a;
        cpu_wdata = 8'ha5;
        cpu_rd = 1'b0;
        cpu_wr = 1'b0;
    end

    task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
        @(posedge clk_sys);
        #1;
        cpu_addr = a;
        cpu_wdata = d;
        cpu_rd = !w;
        cpu_wr = w;
        @(posedge clk_sys);
        #1;
        q = cpu_rdata_q;
        cpu_rd = 1'b0;
        cpu_wr = 1'b0;
        cpu_addr = ~a;
        cpu_wdata = ~d;
    endtask
endmodule

// ---- verif/memory_map_decoder_tb.sv ----
// self-checking bench for the memory map decoder
module memory_map_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, reset, cpu_rd, cpu_wr, sel_io, sel_ram, sel_flash, sel_vector, sel_monitor, mem_wr;
    logic        break_flag_ctl_wr, converter_done_flag, keyboard_irq_flag, voltage_detect_out, voltage_irq;
    logic        high_voltage_enable, mass_select, erase_select, program_select, break_request, watchdog_clear;
    logic [15:0] cpu_addr, vector_addr_q, a;
    logic [7:0]  cpu_wdata, cpu_rdata_q, io_rdata, ram_rdata, flash_rdata, rom_rdata, q;
    logic [7:0]  break_status_in, reset_cause_in, break_flag_ctl_in, irq_status_one_in, irq_status_two_in;
    logic [12:0] irq_pending, p;
    int          n_errors = 0;
    int          n_tests = 0;
    logic [15:0] rst_a [6] = '{16'hfe06, 16'hfe08, 16'hfe0c, 16'hfe0d, 16'hfe0e, 16'hfe0f};
    logic [15:0] rsv_a [5] = '{16'hfe02, 16'hfe07, 16'hfe09, 16'hfe0a, 16'hfe0b};
    logic [15:0] cor_a [19] = '{16'h0000, 16'h003f, 16'h0040, 16'h007f, 16'h0080, 16'h027f, 16'h0280,
        16'hddff, 16'hde00, 16'hfdff, 16'hfe10, 16'hfe1f, 16'hfe20, 16'hff7d, 16'hff7e, 16'hff7f,
        16'hffcf, 16'hffd0, 16'hffff};
    logic [7:0]  fc_w [7] = '{8'h01, 8'h09, 8'h03, 8'hf4, 8'h0e, 8'h0e, 8'h00};
    logic [7:0]  fc_e [7] = '{8'h01, 8'h09, 8'h01, 8'h04, 8'h06, 8'h0e, 8'h00};

    mmd_decoder i_mmd_decoder (.*);
    mmd_cpu_model i_mmd_cpu_model (.*);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        i_mmd_cpu_model.access(ad, d, 1'b1, q);
    endtask
    task automatic rd_chk(input logic [15:0] ad, input logic [7:0] e);
        i_mmd_cpu_model.access(ad, 8'h00, 1'b0, q);
        check(16'(q), 16'(e));
    endtask
    function automatic logic [7:0] exp_rd(input logic [15:0] ad);
        if (ad <= 16'h003f) return io_rdata;
        if (ad >= 16'h0080 && ad <= 16'h027f) return ram_rdata;
        if ((ad >= 16'hde00 && ad <= 16'hfdff) || ad == 16'hff7e || ad >= 16'hffd0) return flash_rdata;
        if (ad >= 16'hfe20 && ad <= 16'hff7d) return rom_rdata;
        return 8'h00;
    endfunction
    task automatic final_report();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end

    initial begin
        reset = 1'b1;
        irq_pending = 13'h0000;
        {converter_done_flag, keyboard_irq_flag, voltage_detect_out} = 3'h0;
        void'($urandom(18830));
        {io_rdata, ram_rdata, flash_rdata, rom_rdata} = $urandom;
        {break_status_in, reset_cause_in, break_flag_ctl_in, irq_status_one_in} = $urandom;
        irq_status_two_in = 8'($urandom);
        repeat (20) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        foreach (rst_a[i]) rd_chk(rst_a[i], 8'h00);
        foreach (rsv_a[i]) begin
            wr(rsv_a[i], 8'hff);
            rd_chk(rsv_a[i], 8'h00);
        end
        rd_chk(16'hfe00, break_status_in);
        rd_chk(16'hfe01, reset_cause_in);
        rd_chk(16'hfe03, break_flag_ctl_in);
        rd_chk(16'hfe04, irq_status_one_in);
        rd_chk(16'hfe05, irq_status_two_in);
        a = {1'b0, 15'($urandom)};
        wr(16'hfe0c, a[15:8]);
        wr(16'hfe0d, a[7:0]);
        rd_chk(16'hfe0c, a[15:8]);
        rd_chk(16'hfe0d, a[7:0]);
        wr(16'hfe0e, 8'h80);
        rd_chk(16'hfe0e, 8'h80);
        rd_chk(a, exp_rd(a));
        rd_chk(16'hfe0e, 8'hc0);
        wr(16'hfe0e, 8'h80);
        rd_chk(16'hfe0e, 8'h80);
        wr(16'hfe0e, 8'h00);
        foreach (fc_w[i]) begin
            wr(16'hfe08, fc_w[i]);
            rd_chk(16'hfe08, fc_e[i]);
            check(16'({high_voltage_enable, mass_select, erase_select, program_select}), 16'(fc_e[i][3:0]));
        end
        voltage_detect_out = 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk(16'hfe0f, 8'ha0);
        wr(16'hfe0f, 8'h40);
        check(16'(voltage_irq), 16'h0001);
        wr(16'hfe0f, 8'h50);
        rd_chk(16'hfe0f, 8'hc0);
        check(16'(voltage_irq), 16'h0000);
        for (int i = 0; i <= 13; i++) begin
            p = 13'($urandom) << i;
            if (i < 13) p[i] = 1'b1;
            irq_pending = p;
            {converter_done_flag, keyboard_irq_flag} = 2'($urandom);
            rd_chk(16'hfe06, {5'h00, converter_done_flag, keyboard_irq_flag, 1'b0});
            check(vector_addr_q, (i < 13) ? mmd_pkg::VEC_ADDR[i] : 16'hfffe);
        end
        foreach (cor_a[i]) rd_chk(cor_a[i], exp_rd(cor_a[i]));
        repeat (300) begin
            a = 16'($urandom);
            if (a[15:4] != 12'hfe0) begin
                wr(a, 8'($urandom));
                rd_chk(a, exp_rd(a));
            end
        end
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        rd_chk(16'hfe0c, 8'h00);
        final_report();
    end
endmodule
